// ==== hdl/mqw_pkg.sv ====
// Constants for the message queue list walker.
// Assumes a byte-addressed shared traffic memory with 32-bit words.
// Notes on behaviour
// - Absent queue treated exactly like empty queue.
// - Zero descriptor or first data pointer: transmit empty.
// - Zero descriptor or first data pointer: receive empty.
// - Transmit end: zero next or following data.
// - Receive end: zero next or following data.
// - Frame table walk sends at most 32 frames.
package mqw_pkg;
   // List record layout, byte offsets within a record
   localparam int REC_DP_OFS = 0;
   localparam int REC_NP_OFS = 4;
   // Words are four bytes apart
   localparam int WORD_SHIFT = 2;
   // Descriptor table entry and stream tag codes
   localparam logic [1:0] KIND_TX0 = 2'h0;
   localparam logic [1:0] KIND_TX1 = 2'h1;
   localparam logic [1:0] KIND_RX = 2'h2;
   localparam logic [1:0] KIND_MF = 2'h3;
   // Completion codes
   localparam logic [1:0] CODE_NONE = 2'h0;
   localparam logic [1:0] CODE_EMPTY = 2'h1;
   localparam logic [1:0] CODE_END = 2'h2;
   localparam logic [1:0] CODE_MF_DONE = 2'h3;
   localparam logic [1:0] CODE_MF_ERR = 2'h0;
   // Frame table limits
   localparam int MF_MAX = 32;
   localparam int MF_CNT_W = 6;
   localparam int MF_REGION_SHIFT = 18;
   // Layout mode that keeps areas at address zero
   localparam logic [1:0] LAYOUT_FIXED = 2'h0;
   localparam int BUF_DEPTH = 2;

   typedef enum logic [3:0] {
      MQW_IDLE = 4'h0,
      MQW_RD_DESC = 4'h1,
      MQW_RD_DP = 4'h3,
      MQW_RD_NP = 4'h2,
      MQW_PUSH = 4'h6,
      MQW_WAIT = 4'h7,
      MQW_MF_RD = 4'h4,
      MQW_MF_PUSH = 4'hC
   } mqw_state_t;
endpackage : mqw_pkg

// ==== hdl/mqw_walker.sv ====
// Linked-list queue and frame table walker with a two-entry out buffer.
// Assumes a single-outstanding memory read port and a consumer that
// pulses block_done once it has moved the block handed out last.
`timescale 1ns/1ps
module mqw_walker #(
   parameter int ADDR_W = 20,
   parameter int DATA_W = 32
) (
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ce,
   // Configuration from host
   input wire logic [1:0] memory_layout_mode,
   input wire logic [ADDR_W-1:0] queue_area_offset,
   input wire logic [ADDR_W-1:0] frame_table_offset,
   // Queue walk request
   input wire logic start_queue,
   input wire logic [1:0] queue_sel,
   input wire logic block_done,
   // Frame table request
   input wire logic start_mf,
   input wire logic [ADDR_W-1:0] mf_table_ptr,
   input wire logic [mqw_pkg::MF_CNT_W-1:0] mf_count,
   // Shared traffic memory read port
   output logic mem_req,
   output logic [ADDR_W-1:0] mem_addr,
   input wire logic mem_rvalid,
   input wire logic [DATA_W-1:0] mem_rdata,
   // Output stream
   output logic out_valid,
   input wire logic out_ready,
   output logic [DATA_W-1:0] out_data,
   output logic [1:0] out_kind,
   output logic out_last,
   // Status
   output logic busy,
   output logic done,
   output logic [1:0] done_code
);
   localparam int ENT_W = DATA_W + 3;

   if (ADDR_W > DATA_W ||
       ADDR_W <= mqw_pkg::MF_REGION_SHIFT) begin : g_bad_addr_w
      $error("mqw_walker: ADDR_W must be in 19..DATA_W");
   end

   mqw_pkg::mqw_state_t state_reg, state_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic [ADDR_W-1:0] np_reg, np_next;
   logic [DATA_W-1:0] dp_reg, dp_next;
   logic [mqw_pkg::MF_CNT_W-1:0] cnt_reg, cnt_next;
   logic [mqw_pkg::MF_CNT_W-1:0] total_reg, total_next;
   logic [1:0] kind_reg, kind_next;
   logic first_reg, first_next;
   logic done_reg, done_next;
   logic [1:0] code_reg, code_next;
   logic push_valid, push_ready, push_last;
   logic [ADDR_W-1:0] rd_ptr, qa_base, ft_base, mf_end;
   logic [ADDR_W-1:0] mf_start;

   // Offsets only count once the host has moved the areas
   assign qa_base = (memory_layout_mode == mqw_pkg::LAYOUT_FIXED) ?
                    '0 : queue_area_offset;
   assign ft_base = (memory_layout_mode == mqw_pkg::LAYOUT_FIXED) ?
                    '0 : frame_table_offset;
   assign rd_ptr = mem_rdata[ADDR_W-1:0];
   assign mf_start = ft_base + mf_table_ptr;
   assign mf_end = mf_start +
      (ADDR_W'(mf_count - 1'b1) << mqw_pkg::WORD_SHIFT);
   assign mem_req = (state_reg == mqw_pkg::MQW_RD_DESC) ||
                    (state_reg == mqw_pkg::MQW_RD_DP) ||
                    (state_reg == mqw_pkg::MQW_RD_NP) ||
                    (state_reg == mqw_pkg::MQW_MF_RD);
   assign mem_addr = addr_reg;
   assign busy = (state_reg != mqw_pkg::MQW_IDLE);
   assign done = done_reg;
   assign done_code = code_reg;

   always_comb begin
      state_next = state_reg;
      addr_next = addr_reg;
      np_next = np_reg;
      dp_next = dp_reg;
      cnt_next = cnt_reg;
      total_next = total_reg;
      kind_next = kind_reg;
      first_next = first_reg;
      done_next = 1'b0;
      code_next = code_reg;
      push_valid = 1'b0;
      push_last = 1'b0;
      unique case (state_reg)
         mqw_pkg::MQW_IDLE: begin
            if (start_mf) begin
               kind_next = mqw_pkg::KIND_MF;
               // Oversized or region-crossing tables are refused
               if (mf_count == '0 ||
                   mf_count > mqw_pkg::MF_CNT_W'(mqw_pkg::MF_MAX) ||
                   mf_end[ADDR_W-1:mqw_pkg::MF_REGION_SHIFT] !=
                   mf_start[ADDR_W-1:mqw_pkg::MF_REGION_SHIFT]) begin
                  done_next = 1'b1;
                  code_next = mqw_pkg::CODE_MF_ERR;
               end else begin
                  addr_next = mf_start;
                  cnt_next = '0;
                  total_next = mf_count;
                  state_next = mqw_pkg::MQW_MF_RD;
               end
            end else if (start_queue) begin
               kind_next = queue_sel;
               first_next = 1'b1;
               addr_next = qa_base +
                  (ADDR_W'(queue_sel) << mqw_pkg::WORD_SHIFT);
               state_next = mqw_pkg::MQW_RD_DESC;
            end
         end
         mqw_pkg::MQW_RD_DESC: begin
            if (mem_rvalid) begin
               if (rd_ptr == '0) begin
                  done_next = 1'b1;
                  code_next = mqw_pkg::CODE_EMPTY;
                  state_next = mqw_pkg::MQW_IDLE;
               end else begin
                  np_next = rd_ptr;
                  addr_next = rd_ptr + ADDR_W'(mqw_pkg::REC_DP_OFS);
                  state_next = mqw_pkg::MQW_RD_DP;
               end
            end
         end
         mqw_pkg::MQW_RD_DP: begin
            if (mem_rvalid) begin
               if (rd_ptr == '0) begin
                  done_next = 1'b1;
                  code_next = first_reg ? mqw_pkg::CODE_EMPTY :
                              mqw_pkg::CODE_END;
                  state_next = mqw_pkg::MQW_IDLE;
               end else begin
                  dp_next = DATA_W'(rd_ptr);
                  addr_next = np_reg + ADDR_W'(mqw_pkg::REC_NP_OFS);
                  state_next = mqw_pkg::MQW_RD_NP;
               end
            end
         end
         mqw_pkg::MQW_RD_NP: begin
            if (mem_rvalid) begin
               np_next = rd_ptr;
               state_next = mqw_pkg::MQW_PUSH;
            end
         end
         mqw_pkg::MQW_PUSH: begin
            push_valid = 1'b1;
            push_last = (np_reg == '0);
            if (push_ready) state_next = mqw_pkg::MQW_WAIT;
         end
         mqw_pkg::MQW_WAIT: begin
            if (block_done) begin
               first_next = 1'b0;
               if (np_reg == '0) begin
                  done_next = 1'b1;
                  code_next = mqw_pkg::CODE_END;
                  state_next = mqw_pkg::MQW_IDLE;
               end else begin
                  addr_next = np_reg + ADDR_W'(mqw_pkg::REC_DP_OFS);
                  state_next = mqw_pkg::MQW_RD_DP;
               end
            end
         end
         mqw_pkg::MQW_MF_RD: begin
            if (mem_rvalid) begin
               dp_next = mem_rdata;
               state_next = mqw_pkg::MQW_MF_PUSH;
            end
         end
         mqw_pkg::MQW_MF_PUSH: begin
            push_valid = 1'b1;
            push_last = (cnt_reg == total_reg - 1'b1);
            if (push_ready) begin
               if (push_last) begin
                  done_next = 1'b1;
                  code_next = mqw_pkg::CODE_MF_DONE;
                  state_next = mqw_pkg::MQW_IDLE;
               end else begin
                  cnt_next = cnt_reg + 1'b1;
                  addr_next = addr_reg +
                     (ADDR_W'(1) << mqw_pkg::WORD_SHIFT);
                  state_next = mqw_pkg::MQW_MF_RD;
               end
            end
         end
         default: state_next = mqw_pkg::MQW_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= mqw_pkg::MQW_IDLE;
         addr_reg <= '0;
         np_reg <= '0;
         dp_reg <= '0;
         cnt_reg <= '0;
         total_reg <= '0;
         kind_reg <= mqw_pkg::KIND_TX0;
         first_reg <= 1'b0;
         done_reg <= 1'b0;
         code_reg <= mqw_pkg::CODE_NONE;
      end else if (ce) begin
         state_reg <= state_next;
         addr_reg <= addr_next;
         np_reg <= np_next;
         dp_reg <= dp_next;
         cnt_reg <= cnt_next;
         total_reg <= total_next;
         kind_reg <= kind_next;
         first_reg <= first_next;
         done_reg <= done_next;
         code_reg <= code_next;
      end
   end

   // Two-entry buffer: a stalled consumer holds the walker in a push state
   logic [ENT_W-1:0] buf_mem [mqw_pkg::BUF_DEPTH];
   logic [ENT_W-1:0] buf_mem_next [mqw_pkg::BUF_DEPTH];
   logic wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
   logic [1:0] buf_cnt_reg, buf_cnt_next;
   logic do_push, do_pop;

   assign push_ready = (buf_cnt_reg != 2'(mqw_pkg::BUF_DEPTH));
   assign out_valid = (buf_cnt_reg != 2'h0);
   assign do_push = push_valid && push_ready;
   assign do_pop = out_valid && out_ready;
   assign {out_kind, out_last, out_data} = buf_mem[rd_ptr_reg];

   always_comb begin
      buf_mem_next = buf_mem;
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      if (do_push) begin
         buf_mem_next[wr_ptr_reg] = {kind_reg, push_last, dp_reg};
         wr_ptr_next = ~wr_ptr_reg;
      end
      if (do_pop) rd_ptr_next = ~rd_ptr_reg;
      buf_cnt_next = buf_cnt_reg + 2'(do_push) - 2'(do_pop);
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < mqw_pkg::BUF_DEPTH; i++) buf_mem[i] <= '0;
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         buf_cnt_reg <= 2'h0;
      end else if (ce) begin
         buf_mem <= buf_mem_next;
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         buf_cnt_reg <= buf_cnt_next;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   property p_desc_zero;
      ce && state_reg == mqw_pkg::MQW_RD_DESC && mem_rvalid && rd_ptr == '0
      |=> done && done_code == mqw_pkg::CODE_EMPTY && !busy;
   endproperty
   a_desc_zero: assert property (p_desc_zero)
      else $error("zero descriptor did not end as empty");
   property p_first_dp_zero;
      ce && state_reg == mqw_pkg::MQW_RD_DP && first_reg && mem_rvalid &&
      rd_ptr == '0 |=> done && done_code == mqw_pkg::CODE_EMPTY;
   endproperty
   a_first_dp_zero: assert property (p_first_dp_zero)
      else $error("zero first data pointer did not end as empty");
   property p_empty_no_data;
      ce && state_reg == mqw_pkg::MQW_RD_DESC && mem_rvalid && rd_ptr == '0
      |=> !push_valid ##1 !push_valid;
   endproperty
   a_empty_no_data: assert property (p_empty_no_data)
      else $error("empty queue produced data");
   property p_np_zero_end;
      ce && state_reg == mqw_pkg::MQW_WAIT && block_done && np_reg == '0
      |=> done && done_code == mqw_pkg::CODE_END && !mem_req;
   endproperty
   a_np_zero_end: assert property (p_np_zero_end)
      else $error("zero next pointer did not end the queue");
   property p_next_dp_zero;
      ce && state_reg == mqw_pkg::MQW_RD_DP && !first_reg && mem_rvalid &&
      rd_ptr == '0 |=> done && done_code == mqw_pkg::CODE_END;
   endproperty
   a_next_dp_zero: assert property (p_next_dp_zero)
      else $error("zero data pointer in next record did not end queue");
   property p_follow_np;
      ce && state_reg == mqw_pkg::MQW_WAIT && block_done && np_reg != '0
      |=> mem_req && mem_addr ==
          $past(np_reg) + ADDR_W'(mqw_pkg::REC_DP_OFS);
   endproperty
   a_follow_np: assert property (p_follow_np)
      else $error("next record not fetched through next pointer");
   property p_mf_limit;
      busy && kind_reg == mqw_pkg::KIND_MF |->
      total_reg <= mqw_pkg::MF_CNT_W'(mqw_pkg::MF_MAX) && cnt_reg < total_reg;
   endproperty
   a_mf_limit: assert property (p_mf_limit)
      else $error("frame table walk beyond its limit");
   property p_mf_finish;
      ce && state_reg == mqw_pkg::MQW_MF_PUSH && push_ready && push_last
      |=> done && done_code == mqw_pkg::CODE_MF_DONE && out_valid;
   endproperty
   a_mf_finish: assert property (p_mf_finish)
      else $error("frame table walk did not finish after last frame");
   property p_out_hold;
      out_valid && (!out_ready || !ce) |=> out_valid && $stable(out_data);
   endproperty
   a_out_hold: assert property (p_out_hold)
      else $error("buffered word lost while stalled");

   c_tx_end: cover property (done && done_code == mqw_pkg::CODE_END);
   c_empty: cover property (done && done_code == mqw_pkg::CODE_EMPTY);
   c_mf: cover property (done && done_code == mqw_pkg::CODE_MF_DONE);
   c_full: cover property (buf_cnt_reg == 2'h2 && push_valid);
endmodule : mqw_walker

// ==== sim/mqw_mem_model.sv ====
// Shared traffic memory model answering single reads at varying delay.
// Assumes one read outstanding; the bench writes host structures here.
`timescale 1ns/1ps
module mqw_mem_model #(
   parameter int ADDR_W = 20,
   parameter int DATA_W = 32
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Read port
   input wire logic mem_req,
   input wire logic [ADDR_W-1:0] mem_addr,
   output logic mem_rvalid,
   output logic [DATA_W-1:0] mem_rdata,
   // Slowest answer in cycles
   input wire logic [3:0] lat_max
);
   // 4 KB mirrored over the whole space to keep the model small
   logic [DATA_W-1:0] words [0:1023];
   logic [3:0] wait_reg;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_rvalid <= 1'b0;
         mem_rdata <= '0;
         wait_reg <= 4'h0;
      end else if (!mem_rvalid && mem_req && wait_reg == 4'h0) begin
         mem_rvalid <= 1'b1;
         mem_rdata <= words[mem_addr[11:2]];
      end else begin
         // Data not valid: keep it moving so a late sample shows
         mem_rvalid <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_rvalid)
            wait_reg <= 4'($urandom_range(0, lat_max));
         else if (mem_req && wait_reg != 4'h0)
            wait_reg <= wait_reg - 4'h1;
      end
   end
   initial begin
      foreach (words[i]) words[i] = '0;
   end
endmodule : mqw_mem_model

// ==== sim/test_message_queue_list_walker.sv ====
// Self-checking bench for the list walker with a memory model.
// Assumes one clock; expected words and codes wait in queues.
`timescale 1ns/1ps
module test_message_queue_list_walker;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic [1:0] memory_layout_mode = 2'h0;
   logic [19:0] queue_area_offset = 20'h00040;
   logic [19:0] frame_table_offset = 20'h00800;
   logic start_queue = 1'b0;
   logic [1:0] queue_sel = 2'h0;
   logic block_done = 1'b0;
   logic start_mf = 1'b0;
   logic [19:0] mf_table_ptr = 20'h00000;
   logic [5:0] mf_count = 6'h00;
   logic out_ready = 1'b0;
   logic mem_req, mem_rvalid, out_valid, out_last, busy, done;
   logic [19:0] mem_addr;
   logic [31:0] mem_rdata, out_data;
   logic [1:0] out_kind, done_code;
   logic [3:0] lat_max = 4'h0;
   logic hold_ready = 1'b0;
   int bd_cnt = 0;
   int err_total = 0;
   int n_compared = 0;
   logic [34:0] exp_word[$];
   logic [1:0] exp_code[$];

   always #12.5 sys_clk = ~sys_clk;

   mqw_walker dut (.sys_clk, .rst_n, .ce, .memory_layout_mode,
      .queue_area_offset, .frame_table_offset, .start_queue, .queue_sel,
      .block_done, .start_mf, .mf_table_ptr, .mf_count, .mem_req,
      .mem_addr, .mem_rvalid, .mem_rdata, .out_valid, .out_ready,
      .out_data, .out_kind, .out_last, .busy, .done, .done_code);
   mqw_mem_model mem (.sys_clk, .rst_n, .mem_req, .mem_addr, .mem_rvalid,
      .mem_rdata, .lat_max);

   task automatic fail(input string msg);
      err_total++;
      $display("unexpected at %0t: %s", $time, msg);
   endtask : fail

   task automatic chk_val(input logic [31:0] act, input logic [31:0] exp);
      n_compared++;
      if (act !== exp) fail($sformatf("level %h, want %h", act, exp));
   endtask : chk_val

   task automatic chk_word();
      n_compared++;
      if (exp_word.size() == 0)
         fail("word not expected");
      else if ({out_data, out_kind, out_last} !== exp_word.pop_front())
         fail($sformatf("word %h kind %h", out_data, out_kind));
   endtask : chk_word

   task automatic chk_code();
      n_compared++;
      if (exp_code.size() == 0)
         fail("done not expected");
      else if (done_code !== exp_code.pop_front())
         fail($sformatf("done code %h", done_code));
   endtask : chk_code

   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop

   task automatic wr(input logic [19:0] a, input logic [31:0] d);
      mem.words[a[11:2]] = d;
   endtask : wr

   task automatic kick(input bit mf, input logic [1:0] sel);
      @(posedge sys_clk);
      queue_sel <= sel;
      start_mf <= mf;
      start_queue <= !mf;
      @(posedge sys_clk);
      start_mf <= 1'b0;
      start_queue <= 1'b0;
   endtask : kick

   task automatic wait_all(input string name);
      int i;
      for (i = 0; i < 4000 && (exp_code.size() || exp_word.size()); i++)
         @(posedge sys_clk);
      if (i == 4000) fail("no completion");
      repeat (5) @(posedge sys_clk);
      $display("test %s ended", name);
   endtask : wait_all

   task automatic run_queue(input logic [1:0] sel, input int nrec,
         input bit term, input logic [1:0] mode);
      logic [19:0] rb;
      logic [19:0] np;
      logic [31:0] dp;
      rb = 20'h00200;
      wr((mode == mqw_pkg::LAYOUT_FIXED ? 20'h00000 : queue_area_offset)
         + 20'(4 * sel), (nrec == 0 && !term) ? 32'h0 : {12'h000, rb});
      for (int i = 0; i < nrec; i++) begin
         dp = {12'h000, 20'($urandom_range(1, 20'hFFFFF))};
         np = (i == nrec - 1 && !term) ? 20'h00000 : rb + 20'(8 * i + 8);
         wr(rb + 20'(8 * i), dp);
         wr(rb + 20'(8 * i + 4), {12'h000, np});
         exp_word.push_back({dp, sel, 1'(np == 20'h00000)});
      end
      // Spare ring block: zero data pointer, next pointer back to the head
      if (term) begin
         wr(rb + 20'(8 * nrec), 32'h0);
         wr(rb + 20'(8 * nrec + 4), {12'h000, rb});
      end
      exp_code.push_back(nrec == 0 ? mqw_pkg::CODE_EMPTY : mqw_pkg::CODE_END);
      memory_layout_mode <= mode;
      kick(1'b0, sel);
      wait_all("queue");
   endtask : run_queue

   task automatic run_mf(input logic [19:0] fo, input logic [19:0] ptr,
         input int cnt, input bit ok, input bit wt);
      logic [31:0] w;
      for (int i = 0; i < cnt && ok; i++) begin
         w = $urandom;
         wr(fo + ptr + 20'(4 * i), w);
         exp_word.push_back({w, mqw_pkg::KIND_MF, 1'(i == cnt - 1)});
      end
      exp_code.push_back(ok ? mqw_pkg::CODE_MF_DONE : mqw_pkg::CODE_MF_ERR);
      memory_layout_mode <= 2'h1;
      frame_table_offset <= fo;
      mf_table_ptr <= ptr;
      mf_count <= 6'(cnt);
      kick(1'b1, 2'h0);
      if (wt) wait_all("frame table");
   endtask : run_mf

   // Consumer: random stalls, block finished a few cycles after taking it
   always @(posedge sys_clk) begin
      block_done <= (bd_cnt == 1);
      if (bd_cnt > 0) bd_cnt <= bd_cnt - 1;
      out_ready <= !hold_ready && ($urandom_range(0, 3) != 0);
      if (rst_n && out_valid === 1'b1 && out_ready === 1'b1) begin
         if (out_kind !== mqw_pkg::KIND_MF) bd_cnt <= 3;
         chk_word();
      end
      if (rst_n && done === 1'b1) chk_code();
   end

   initial begin
      void'($urandom(92));
      repeat (8) @(posedge sys_clk);
      #5 rst_n = 1'b1;
      @(posedge sys_clk);
      for (int s = 0; s < 3; s++) begin
         run_queue(2'(s), 0, 1'b0, 2'h0);
         run_queue(2'(s), 0, 1'b1, 2'h1);
         run_queue(2'(s), 3, 1'b0, 2'h1);
         run_queue(2'(s), 2, 1'b1, 2'h0);
      end
      lat_max <= 4'h5;
      run_queue(2'h1, 4, 1'b1, 2'h1);
      run_mf(20'h00800, 20'h00080, 1, 1'b1, 1'b1);
      hold_ready <= 1'b1;
      run_mf(20'h00800, 20'h00080, 32, 1'b1, 1'b0);
      // A queue request while the table runs must be ignored
      kick(1'b0, 2'h0);
      repeat (40) @(posedge sys_clk);
      // Freeze only once the walker is parked with no read pending
      ce <= 1'b0;
      repeat (10) @(posedge sys_clk);
      ce <= 1'b1;
      repeat (10) @(posedge sys_clk);
      chk_val(32'(out_valid), 32'h1);
      chk_val(32'(busy), 32'h1);
      hold_ready <= 1'b0;
      wait_all("full buffer");
      run_mf(20'h00800, 20'h00080, 33, 1'b0, 1'b1);
      run_mf(20'h00800, 20'h00080, 0, 1'b0, 1'b1);
      run_mf(20'h00000, 20'h3FFF8, 2, 1'b1, 1'b1);
      run_mf(20'h00000, 20'h3FFF8, 3, 1'b0, 1'b1);
      report_and_stop();
   end

   initial begin
      repeat (40000) @(posedge sys_clk);
      fail("watchdog expired");
      report_and_stop();
   end
endmodule : test_message_queue_list_walker
